//--- shared/tidc_consts.svh
`ifndef TIDC_CONSTS_SVH
`define TIDC_CONSTS_SVH
`define TIDC_NUM_INPUTS 17
`define TIDC_FILT_DEFAULT_MS 10
`define TIDC_FILT_MAX_MS 1000
`define TIDC_CLK_HZ 20000000
`define TIDC_CYC_PER_MS (`TIDC_CLK_HZ / 1000)
`define TIDC_PCT_FULL 1000
`define TIDC_USER_FAULT_ONE_CODE 8'h1B
`define TIDC_USER_FAULT_TWO_CODE 8'h1C
`define TIDC_PID_SW_TERMINAL 2'h1
`define TIDC_IN_STEP0 0
`define TIDC_IN_STEP1 1
`define TIDC_IN_STEP2 2
`define TIDC_IN_STEP3 3
`define TIDC_IN_RAMP1 4
`define TIDC_IN_RAMP2 5
`define TIDC_IN_MOTOR1 6
`define TIDC_IN_MOTOR2 7
`define TIDC_IN_PIDSW 8
`define TIDC_IN_UFLT1 9
`define TIDC_IN_UFLT2 10
`define TIDC_IN_SPTQ 11
`define TIDC_IN_ESTOP 12
`define TIDC_IN_XSTOP2 13
`define TIDC_IN_BRKDEC 14
`define TIDC_IN_RTCLR 15
`define TIDC_IN_YPRESET 16
`endif

//--- shared/tidc_pkg.sv
package tidc_pkg;
  typedef enum logic [1:0]
  {
    SCHEME_TWO_WIRE_ONE = 2'b00,
    SCHEME_TWO_WIRE_TWO = 2'b01,
    SCHEME_THREE_WIRE_ONE = 2'b10,
    SCHEME_THREE_WIRE_TWO = 2'b11
  } tidc_scheme_t;

  typedef struct packed {
    logic run;
    logic reverse;
  } tidc_run_t;

  typedef struct packed {
    logic emergencyStop;
    logic extStopTwo;
    logic brakeDecel;
    logic runTimeClear;
    logic ySubstPreset;
    logic altControlMode;
    logic pidSetTwo;
    logic [1:0] motorSet;
    logic [1:0] rampSet;
    logic [3:0] stepIndex;
  } tidc_cmd_t;
endpackage

//--- hw/tidc_decoder.sv
`include "tidc_consts.svh"
module tidc_decoder #(
  parameter int NUM_IN = `TIDC_NUM_INPUTS,
  parameter int CYC_PER_MS = `TIDC_CYC_PER_MS,
  parameter int FREQ_W = 16
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NUM_IN-1:0] funcTerm,
  input wire logic inputOne,
  input wire logic inputTwo,
  input wire logic inputThree,
  input wire logic [10:0] inputFilterTime,
  input wire logic [1:0] terminalCommandScheme,
  input wire logic [1:0] pidSetSwitchCondition,
  input wire logic baseTorqueMode,
  input wire logic [15:0] stepValue [16],
  input wire logic [FREQ_W-1:0] maxOutputFrequency,
  output tidc_pkg::tidc_cmd_t cmd_ff,
  output tidc_pkg::tidc_run_t runCmd_ff,
  output logic torqueMode_ff,
  output logic [FREQ_W-1:0] stepFrequency_ff,
  output logic faultValid_ff,
  output logic [7:0] faultCode_ff
);
  localparam int TOTAL = NUM_IN + 3;
  localparam int CNT_W = 32;

  // The input map is fixed by the terminal index constants
  if (NUM_IN != `TIDC_NUM_INPUTS || CYC_PER_MS < 1 || FREQ_W < 1 || FREQ_W > 16)
  begin : g_bad_param
    $error("tidc_decoder: unsupported parameters");
  end

  logic [TOTAL-1:0] rawIn;
  logic [TOTAL-1:0] syncA_ff;
  logic [TOTAL-1:0] syncB_ff;
  logic [TOTAL-1:0] filt_ff;
  logic [10:0] filtMs;
  logic [CNT_W-1:0] msCnt_ff;
  logic msTick_ff;

  assign rawIn = {inputThree, inputTwo, inputOne, funcTerm};
  // Out-of-range settings clamp to the top of the range
  assign filtMs = (inputFilterTime > 11'(`TIDC_FILT_MAX_MS)) ? 11'(`TIDC_FILT_MAX_MS)
                  : inputFilterTime;

  // Two flops per pin keep metastability away from the filter logic
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end
    else
    begin
      syncA_ff <= rawIn;
      syncB_ff <= syncA_ff;
    end
  end

  // Shared millisecond tick keeps one wide divider instead of one per input
  // Tick phase runs free, so acceptance jitters by up to one tick
  always_ff @(posedge core_clk)
  begin
    if (rst || msCnt_ff == CNT_W'(CYC_PER_MS - 1))
    begin
      msCnt_ff <= '0;
      msTick_ff <= ~rst;
    end
    else
    begin
      msCnt_ff <= msCnt_ff + 1'b1;
      msTick_ff <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < TOTAL; gi++)
    begin : g_filt
      logic [10:0] stable_ff;
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          stable_ff <= '0;
          filt_ff[gi] <= 1'b0;
        end
        else if (syncB_ff[gi] == filt_ff[gi])
        begin
          stable_ff <= '0;
        end
        else if (filtMs == 11'h000)
        begin
          filt_ff[gi] <= syncB_ff[gi];
        end
        else if (msTick_ff)
        begin
          // A change can meet a tick at once, so one extra tick is counted;
          // the new level has then stood for at least the full filter time
          if (stable_ff >= filtMs)
          begin
            filt_ff[gi] <= syncB_ff[gi];
            stable_ff <= '0;
          end
          else
          begin
            stable_ff <= stable_ff + 11'h001;
          end
        end
      end
    end
  endgenerate

  logic fOne;
  logic fTwo;
  logic fThree;
  logic fOneD_ff;
  logic fTwoD_ff;
  logic riseOne;
  logic riseTwo;
  logic stopAll;
  tidc_pkg::tidc_scheme_t scheme;

  assign fOne = filt_ff[NUM_IN];
  assign fTwo = filt_ff[NUM_IN+1];
  assign fThree = filt_ff[NUM_IN+2];
  assign riseOne = fOne & ~fOneD_ff;
  assign riseTwo = fTwo & ~fTwoD_ff;
  assign scheme = tidc_pkg::tidc_scheme_t'(terminalCommandScheme);
  // Emergency stop and ext stop two both drop the run request
  assign stopAll = filt_ff[`TIDC_IN_XSTOP2] | filt_ff[`TIDC_IN_ESTOP];

  // Edge history resets low, the idle level of an open contact
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fOneD_ff <= 1'b0;
      fTwoD_ff <= 1'b0;
    end
    else
    begin
      fOneD_ff <= fOne;
      fTwoD_ff <= fTwo;
    end
  end

  // Stops win over every scheme; a three-wire restart needs a new edge
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      runCmd_ff <= '0;
    end
    else if (stopAll)
    begin
      runCmd_ff.run <= 1'b0;
    end
    else
    begin
      unique case (scheme)
        tidc_pkg::SCHEME_TWO_WIRE_ONE:
        begin
          runCmd_ff.run <= fOne ^ fTwo;
          if (fOne ^ fTwo)
          begin
            runCmd_ff.reverse <= fTwo;
          end
        end
        tidc_pkg::SCHEME_TWO_WIRE_TWO:
        begin
          runCmd_ff.run <= fOne;
          runCmd_ff.reverse <= fTwo;
        end
        tidc_pkg::SCHEME_THREE_WIRE_ONE:
        begin
          if (!fThree)
          begin
            runCmd_ff.run <= 1'b0;
          end
          else if (riseOne)
          begin
            runCmd_ff <= '{run: 1'b1, reverse: 1'b0};
          end
          else if (riseTwo)
          begin
            runCmd_ff <= '{run: 1'b1, reverse: 1'b1};
          end
        end
        tidc_pkg::SCHEME_THREE_WIRE_TWO:
        begin
          if (!fThree)
          begin
            runCmd_ff.run <= 1'b0;
          end
          else
          begin
            if (riseOne)
            begin
              runCmd_ff.run <= 1'b1;
            end
            runCmd_ff.reverse <= fTwo;
          end
        end
      endcase
    end
  end

  logic [3:0] stepIdx;
  logic [31:0] scaled;

  assign stepIdx = {filt_ff[`TIDC_IN_STEP3], filt_ff[`TIDC_IN_STEP2],
                    filt_ff[`TIDC_IN_STEP1], filt_ff[`TIDC_IN_STEP0]};
  // Step values are in 0.1 percent units; 1000 equals full scale
  // Both factors fit in 16 bits, so the 32-bit product cannot overflow
  assign scaled = (32'(stepValue[stepIdx]) * 32'(maxOutputFrequency))
                  / 32'(`TIDC_PCT_FULL);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cmd_ff <= '0;
      torqueMode_ff <= 1'b0;
      stepFrequency_ff <= '0;
    end
    else
    begin
      cmd_ff.stepIndex <= stepIdx;
      stepFrequency_ff <= FREQ_W'(scaled);
      // Ext stop two forces set four so the stop uses decel time four
      cmd_ff.rampSet <= filt_ff[`TIDC_IN_XSTOP2] ? 2'h3
                        : {filt_ff[`TIDC_IN_RAMP2], filt_ff[`TIDC_IN_RAMP1]};
      // Only motor one and motor two are defined; other combinations keep motor one
      cmd_ff.motorSet <= (filt_ff[`TIDC_IN_MOTOR1] && !filt_ff[`TIDC_IN_MOTOR2]) ? 2'h1
                         : 2'h0;
      cmd_ff.pidSetTwo <= (pidSetSwitchCondition == `TIDC_PID_SW_TERMINAL)
                          && filt_ff[`TIDC_IN_PIDSW];
      cmd_ff.altControlMode <= filt_ff[`TIDC_IN_SPTQ];
      torqueMode_ff <= baseTorqueMode ^ filt_ff[`TIDC_IN_SPTQ];
      cmd_ff.emergencyStop <= filt_ff[`TIDC_IN_ESTOP];
      cmd_ff.extStopTwo <= filt_ff[`TIDC_IN_XSTOP2];
      cmd_ff.brakeDecel <= filt_ff[`TIDC_IN_BRKDEC];
      cmd_ff.runTimeClear <= filt_ff[`TIDC_IN_RTCLR];
      cmd_ff.ySubstPreset <= filt_ff[`TIDC_IN_YPRESET];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      faultValid_ff <= 1'b0;
      faultCode_ff <= 8'h00;
    end
    else
    begin
      // Fault one takes priority when both are active
      // The code clears to zero as soon as both terminals are released
      faultValid_ff <= filt_ff[`TIDC_IN_UFLT1] | filt_ff[`TIDC_IN_UFLT2];
      if (filt_ff[`TIDC_IN_UFLT1])
      begin
        faultCode_ff <= `TIDC_USER_FAULT_ONE_CODE;
      end
      else if (filt_ff[`TIDC_IN_UFLT2])
      begin
        faultCode_ff <= `TIDC_USER_FAULT_TWO_CODE;
      end
      else
      begin
        faultCode_ff <= 8'h00;
      end
    end
  end
endmodule

//--- verification/tidc_dec_asserts.sv
module tidc_dec_asserts #(
  parameter int NUM_IN = 17
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NUM_IN-1:0] funcTerm,
  input wire logic inputOne,
  input wire logic inputTwo,
  input wire logic inputThree,
  input wire logic [10:0] inputFilterTime,
  input wire logic [1:0] terminalCommandScheme,
  input wire logic [1:0] pidSetSwitchCondition,
  input wire logic baseTorqueMode,
  input wire tidc_pkg::tidc_cmd_t cmd_ff,
  input wire tidc_pkg::tidc_run_t runCmd_ff,
  input wire logic torqueMode_ff,
  input wire logic faultValid_ff,
  input wire logic [7:0] faultCode_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fixed four-edge latency only holds with the filter off, so checks wait for that
  logic [2:0] zCnt_ff;
  logic ok;
  logic [4:0] stopIn;
  logic [1:0] sch;
  always_ff @(posedge core_clk)
  begin
    if (rst || inputFilterTime != 11'h000)
      zCnt_ff <= 3'h0;
    else if (zCnt_ff != 3'h7)
      zCnt_ff <= zCnt_ff + 3'h1;
  end
  assign ok = zCnt_ff == 3'h7;
  assign stopIn = {funcTerm[12], funcTerm[13], funcTerm[14], funcTerm[15], funcTerm[16]};
  assign sch = terminalCommandScheme;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_step_index: assert property (ok |-> cmd_ff.stepIndex == $past(funcTerm[3:0], 4))
    else $error("step index wrong");
  a_ramp_set: assert property (ok |-> cmd_ff.rampSet ==
    ($past(funcTerm[13], 4) ? 2'h3 : $past(funcTerm[5:4], 4))) else $error("ramp set wrong");
  a_motor_set: assert property (ok |-> cmd_ff.motorSet == {1'b0, $past(funcTerm[7:6] == 2'h1, 4)})
    else $error("motor set wrong");
  a_pid_set: assert property (ok |-> cmd_ff.pidSetTwo ==
    ($past(pidSetSwitchCondition, 1) == 2'h1 && $past(funcTerm[8], 4)))
    else $error("pid set wrong");
  a_user_fault: assert property (ok |-> faultValid_ff == $past(|funcTerm[10:9], 4) &&
    faultCode_ff == ($past(funcTerm[9], 4) ? 8'h1B : $past(funcTerm[10], 4) ? 8'h1C : 8'h00))
    else $error("fault code wrong");
  a_torque_mode: assert property (ok |->
    torqueMode_ff == ($past(baseTorqueMode, 1) ^ $past(funcTerm[11], 4)))
    else $error("torque mode wrong");
  a_stop_flags: assert property (ok |-> cmd_ff[14:10] == $past(stopIn, 4))
    else $error("stop flags wrong");
  a_two_wire: assert property (ok && sch == 2'h0 && $past(sch, 4) == 2'h0 |->
    runCmd_ff.run == $past((inputOne ^ inputTwo) && stopIn[4:3] == 2'h0, 4) &&
    (!runCmd_ff.run || runCmd_ff.reverse == $past(inputTwo, 4))) else $error("two-wire run wrong");
  a_three_stop: assert property (ok && sch[1] && $past(sch[1] && !inputThree, 4)
    |-> !runCmd_ff.run) else $error("run while stop open");
  c_reverse: cover property (ok && sch[1] && runCmd_ff.run && runCmd_ff.reverse);
  c_fault_two: cover property (faultValid_ff && faultCode_ff == 8'h1C);
  c_ext_stop: cover property (cmd_ff.extStopTwo && cmd_ff.rampSet == 2'h3);
endmodule
bind tidc_decoder tidc_dec_asserts #(.NUM_IN(NUM_IN)) u_tidc_dec_asserts (.core_clk, .rst,
  .funcTerm, .inputOne, .inputTwo, .inputThree, .inputFilterTime, .terminalCommandScheme,
  .pidSetSwitchCondition, .baseTorqueMode, .cmd_ff, .runCmd_ff, .torqueMode_ff, .faultValid_ff,
  .faultCode_ff);

//--- verification/tidc_switch_model.sv
module tidc_switch_model (
  input wire logic core_clk,
  input wire logic [19:0] want,
  input wire logic chatter,
  output logic [19:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  // Bounce flips every contact each cycle, so no level outlasts a filter window
  always @(posedge core_clk)
  begin
    flip <= ~flip;
    pins <= #1 (chatter && flip) ? ~want : want;
  end
endmodule

//--- verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic chatter = 1'b0;
  logic baseTq = 1'b0;
  logic [19:0] want = '0;
  logic [19:0] pins;
  logic [10:0] filt = 11'h000;
  logic [1:0] scheme = 2'h0;
  logic [1:0] pidCond = 2'h1;
  logic [15:0] stepVal [16];
  logic [15:0] stepFreq;
  logic [7:0] fltCode;
  logic tqMode;
  logic fltValid;
  tidc_pkg::tidc_cmd_t cmd;
  tidc_pkg::tidc_run_t runCmd;
  int num_errors = 0;
  int check_count = 0;
  // Per entry: scheme, {three, two, one}, expected {run, run and reverse}
  logic [6:0] runSeq [16] = '{7'h06, 7'h0B, 7'h0C, 7'h26, 7'h2F, 7'h28, 7'h44, 7'h50,
    7'h56, 7'h52, 7'h5B, 7'h48, 7'h70, 7'h7F, 7'h72, 7'h60};
  always #25 core_clk = ~core_clk;
  tidc_switch_model u_tidc_switch_model (.core_clk(core_clk), .want(want), .chatter(chatter),
    .pins(pins));
  tidc_decoder #(.CYC_PER_MS(4)) u_tidc_decoder (.core_clk(core_clk), .rst(rst),
    .funcTerm(pins[16:0]), .inputOne(pins[17]), .inputTwo(pins[18]), .inputThree(pins[19]),
    .inputFilterTime(filt), .terminalCommandScheme(scheme), .pidSetSwitchCondition(pidCond),
    .baseTorqueMode(baseTq), .stepValue(stepVal), .maxOutputFrequency(16'h3039),
    .cmd_ff(cmd), .runCmd_ff(runCmd), .torqueMode_ff(tqMode), .stepFrequency_ff(stepFreq),
    .faultValid_ff(fltValid), .faultCode_ff(fltCode));
  task chk(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
      num_errors++;
    end
  endtask
  task put(input logic [19:0] w);
    want = w;
    repeat (10) @(posedge core_clk);
    #1;
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    finish_test;
  end
  initial
  begin
    for (int i = 0; i < 16; i++)
      stepVal[i] = 16'(i * 100);
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk(16'h0000, {1'b0, cmd});
    chk(16'h0000, {fltValid, 5'h00, runCmd, fltCode});
    for (int k = 0; k < 16; k++)
    begin
      put(20'(k));
      chk(16'(k), 16'(cmd.stepIndex));
      chk(16'(k * 100 * 12345 / 1000), stepFreq);
    end
    for (int r = 0; r < 4; r++)
    begin
      baseTq = r[1];
      pidCond = (r == 1) ? 2'h0 : 2'h1;
      put((20'(r) << 4) | (20'(r) << 6) | (20'(r & 1) << 8) | (20'(r) << 9) | (20'(r & 1) << 11));
      chk(16'(r), 16'(cmd.rampSet));
      chk(16'(r == 1), 16'(cmd.motorSet));
      chk(16'(r == 3), 16'(cmd.pidSetTwo));
      chk(r[0] ? 16'h011B : r[1] ? 16'h011C : 16'h0000, {7'h00, fltValid, fltCode});
      chk(16'(r[0] ^ r[1]), 16'(tqMode));
      chk(16'(r & 1), 16'(cmd.altControlMode));
    end
    for (int b = 12; b < 17; b++)
    begin
      put(20'h20000 | (20'h1 << b));
      chk(16'h0010 >> (b - 12), 16'(cmd[14:10]));
      chk(16'(b > 13), 16'(runCmd.run));
      chk(16'(b == 13 ? 3 : 0), 16'(cmd.rampSet));
    end
    for (int s = 0; s < 16; s++)
    begin
      scheme = runSeq[s][6:5];
      put(20'(runSeq[s][4:2]) << 17);
      chk(16'(runSeq[s][1:0]), {14'h0, runCmd.run, runCmd.run & runCmd.reverse});
    end
    filt = 11'h001;
    chatter = 1'b1;
    put(20'h00005);
    chk(16'h0000, 16'(cmd.stepIndex));
    chatter = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(16'h0000, 16'(cmd.stepIndex));
    repeat (12) @(posedge core_clk);
    #1;
    chk(16'h0005, 16'(cmd.stepIndex));
    finish_test;
  end
endmodule
